/* File: hw/ecl_params.svh */
// Purpose: Constants of the external memory configuration loader
// Assumes: Byte addresses on the register bus, 40 MHz core clock
// Notes:   Definitions only
`ifndef ECL_PARAMS_SVH
`define ECL_PARAMS_SVH
// Configuration byte addresses at the top of external space
`define ECL_CFG0_ADDR    24'hfffff8
`define ECL_CFG1_ADDR    24'hfffff9
// Register byte offsets
`define ECL_REG_CFG0     8'h00
`define ECL_REG_CFG1     8'h04
`define ECL_REG_STAT     8'h08
`define ECL_REG_CALC     8'h0c
`define ECL_REG_RES      8'h10
// Byte zero fields
`define ECL_B0_GWAIT_HI  6
`define ECL_B0_GWAIT_LO  5
`define ECL_B0_SEL_HI    3
`define ECL_B0_SEL_LO    2
`define ECL_B0_PAGE      1
// Byte one fields
`define ECL_B1_CODE32    7
`define ECL_B1_FRAME     4
`define ECL_B1_R1_ONE    3
`define ECL_B1_R1W_HI    2
`define ECL_B1_R1W_LO    1
`define ECL_B1_MIRROR_N  0
// Timing: clocks per state, worst case fetch of 2 states plus 3 waits
`define ECL_CLK_PER_STATE 2
`define ECL_FETCH_STATES  5
`define ECL_FETCH_CYC     (`ECL_FETCH_STATES * `ECL_CLK_PER_STATE)
`define ECL_SYNC_LAT      2
`define ECL_FETCH_LAST    5'd11
// Memory signal select codes
`define ECL_SEL_256K      2'b00
`define ECL_SEL_128K      2'b01
`define ECL_SEL_SPLIT     2'b11
`endif

/* File: hw/ecl_pkg.sv */
// Purpose: Types of the external memory configuration loader
// Assumes: Used by ecl_config_loader only
// Notes:   Constants live in ecl_params.svh
package ecl_pkg;
    // Reset-time load sequence, one-hot
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_F0A  = 5'b00010,
        ST_F0B  = 5'b00100,
        ST_F1   = 5'b01000,
        ST_DONE = 5'b10000
    } ecl_state_t;
endpackage

/* File: hw/ecl_config_loader.sv */
// Purpose: Fetch two configuration bytes at reset and apply memory bus setup
// Assumes: AHB-Lite slave, one clock, pins synchronised in two stages
// Notes:   Settings freeze once loaded, until the next reset
//
// The register addresses and register access over AHB-Lite were left to the implementer.
`timescale 1ns/1ps
`include "ecl_params.svh"

module ecl_config_loader (
    // Clock, reset, enable
    input  wire logic        core_clk_in,
    input  wire logic        rst_in,
    input  wire logic        ce_in,
    // AHB-Lite slave
    input  wire logic        hsel_in,
    input  wire logic [31:0] haddr_in,
    input  wire logic [1:0]  htrans_in,
    input  wire logic        hwrite_in,
    input  wire logic [2:0]  hsize_in,
    input  wire logic [31:0] hwdata_in,
    input  wire logic        hready_in,
    output logic      [31:0] hrdata_out,
    output logic             hreadyout_out,
    output logic             hresp_out,
    // Pins and on-chip configuration source
    input  wire logic        external_access_n_in,
    input  wire logic        port2_bit1_in,
    input  wire logic [7:0]  ext_data_in,
    input  wire logic [7:0]  onchip_cfg0_in,
    input  wire logic [7:0]  onchip_cfg1_in,
    // External fetch
    output logic      [23:0] ext_addr_out,
    output logic             program_store_strobe_n_out,
    // Applied settings, done flag and state tick
    output logic             cfg_done_out,
    output logic             page_mode_out,
    output logic             port1_bit7_a17_out,
    output logic             port3_bit7_a16_out,
    output logic             port3_bit7_rd_out,
    output logic             prog_strobe_reads_all_out,
    output logic      [1:0]  general_wait_out,
    output logic      [2:0]  region1_wait_out,
    output logic      [2:0]  stack_bytes_out,
    output logic             code_32k_out,
    output logic             code_mirror_en_out,
    output logic             prefetch_en_out,
    output logic             wide_fetch_out,
    output logic             state_tick_out
);

    // ****************************************************
    // Pin synchronisers
    // ****************************************************
    logic [9:0] sync1_r;
    logic [9:0] sync2_r;
    logic       acc_s;
    logic       p21_s;
    logic [7:0] data_s;
    assign acc_s  = sync2_r[9];
    assign p21_s  = sync2_r[8];
    assign data_s = sync2_r[7:0];

    // First stage feeds only the second stage
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_r <= 10'h3ff;
            sync2_r <= 10'h3ff;
        end else if (ce_in) begin
            sync1_r <= {external_access_n_in, port2_bit1_in, ext_data_in};
            sync2_r <= sync1_r;
        end
    end

    // ****************************************************
    // Load sequence
    // ****************************************************
    ecl_pkg::ecl_state_t st_r, st_nxt;
    logic [4:0]  cnt_r, cnt_nxt;
    logic [7:0]  cfg0_r, cfg0_nxt;
    logic [7:0]  cfg1_r, cfg1_nxt;
    logic        page_r, page_nxt;
    logic        ext_r, ext_nxt;
    logic [23:0] addr_r, addr_nxt;
    logic        strb_r, strb_nxt;
    logic        last;
    // Data is read through the synchroniser, so the strobe is held 2 extra clocks
    assign last = (cnt_r == `ECL_FETCH_LAST);

    always_comb begin
        st_nxt   = st_r;
        cnt_nxt  = cnt_r;
        cfg0_nxt = cfg0_r;
        cfg1_nxt = cfg1_r;
        page_nxt = page_r;
        ext_nxt  = ext_r;
        addr_nxt = addr_r;
        strb_nxt = 1'b1;
        case (st_r)
            ecl_pkg::ST_IDLE: begin
                cnt_nxt = cnt_r + 5'd1;
                if (cnt_r == 5'(`ECL_SYNC_LAT)) begin
                    cnt_nxt = 5'd0;
                    if (acc_s) begin
                        cfg0_nxt = onchip_cfg0_in;
                        cfg1_nxt = onchip_cfg1_in;
                        page_nxt = ~onchip_cfg0_in[`ECL_B0_PAGE];
                        st_nxt   = ecl_pkg::ST_DONE;
                    end else begin
                        ext_nxt  = 1'b1;
                        addr_nxt = `ECL_CFG0_ADDR;
                        strb_nxt = 1'b0;
                        st_nxt   = ecl_pkg::ST_F0A;
                    end
                end
            end
            ecl_pkg::ST_F0A, ecl_pkg::ST_F0B, ecl_pkg::ST_F1: begin
                cnt_nxt  = cnt_r + 5'd1;
                // Strobe high one clock between fetches, so each is a bus cycle
                strb_nxt = last;
                if (last) begin
                    cnt_nxt = 5'd0;
                    if (st_r == ecl_pkg::ST_F0A) begin
                        page_nxt = ~p21_s;
                        st_nxt   = ecl_pkg::ST_F0B;
                    end else if (st_r == ecl_pkg::ST_F0B) begin
                        cfg0_nxt = data_s;
                        addr_nxt = `ECL_CFG1_ADDR;
                        st_nxt   = ecl_pkg::ST_F1;
                    end else begin
                        cfg1_nxt = data_s;
                        st_nxt   = ecl_pkg::ST_DONE;
                    end
                end
            end
            ecl_pkg::ST_DONE: st_nxt = ecl_pkg::ST_DONE;
            default: st_nxt = ecl_pkg::ST_IDLE;
        endcase
    end

    // Sequence registers
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            st_r   <= ecl_pkg::ST_IDLE;
            cnt_r  <= 5'd0;
            cfg0_r <= 8'hff;
            cfg1_r <= 8'hff;
            page_r <= 1'b0;
            ext_r  <= 1'b0;
            addr_r <= 24'h000000;
            strb_r <= 1'b1;
        end else if (ce_in) begin
            st_r   <= st_nxt;
            cnt_r  <= cnt_nxt;
            cfg0_r <= cfg0_nxt;
            cfg1_r <= cfg1_nxt;
            page_r <= page_nxt;
            ext_r  <= ext_nxt;
            addr_r <= addr_nxt;
            strb_r <= strb_nxt;
        end
    end
    assign ext_addr_out               = addr_r;
    assign program_store_strobe_n_out = strb_r;

    // ****************************************************
    // Applied settings, loaded once
    // ****************************************************
    logic [15:0] set_r, set_nxt;
    logic [2:0]  stk_r, stk_nxt;
    logic        done_r, done_nxt;
    logic [1:0]  sel;
    assign sel = {cfg0_r[`ECL_B0_SEL_HI], cfg0_r[`ECL_B0_SEL_LO]};

    // Reserved byte one bits are not checked; the source keeps them set
    always_comb begin
        set_nxt  = set_r;
        stk_nxt  = stk_r;
        done_nxt = done_r;
        if (st_r == ecl_pkg::ST_DONE && !done_r) begin
            done_nxt     = 1'b1;
            set_nxt[0]   = page_r;
            set_nxt[1]   = (sel == `ECL_SEL_256K);
            set_nxt[2]   = (sel == `ECL_SEL_256K) || (sel == `ECL_SEL_128K);
            set_nxt[3]   = (sel == `ECL_SEL_SPLIT);
            set_nxt[4]   = (sel != `ECL_SEL_SPLIT);
            set_nxt[6:5] = ~{cfg0_r[`ECL_B0_GWAIT_HI], cfg0_r[`ECL_B0_GWAIT_LO]};
            // Field waits plus the legacy single wait, up to four
            set_nxt[9:7] = {1'b0, ~cfg1_r[`ECL_B1_R1W_HI], ~cfg1_r[`ECL_B1_R1W_LO]}
                         + {2'b00, ~cfg1_r[`ECL_B1_R1_ONE]};
            set_nxt[10]  = cfg1_r[`ECL_B1_FRAME];
            set_nxt[11]  = cfg1_r[`ECL_B1_CODE32];
            set_nxt[12]  = ~cfg1_r[`ECL_B1_MIRROR_N];
            stk_nxt      = cfg1_r[`ECL_B1_FRAME] ? 3'd4 : 3'd2;
            set_nxt[13]  = ext_r;
            set_nxt[14]  = ~ext_r;
            set_nxt[15]  = 1'b0;
        end
    end

    // Settings registers
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            set_r  <= 16'h0000;
            stk_r  <= 3'd2;
            done_r <= 1'b0;
        end else if (ce_in) begin
            set_r  <= set_nxt;
            stk_r  <= stk_nxt;
            done_r <= done_nxt;
        end
    end
    assign cfg_done_out       = done_r;
    assign page_mode_out      = set_r[0];
    assign port1_bit7_a17_out = set_r[1];
    assign port3_bit7_a16_out = set_r[2];
    assign port3_bit7_rd_out  = set_r[3];
    assign prog_strobe_reads_all_out = set_r[4];
    assign general_wait_out   = set_r[6:5];
    assign region1_wait_out   = set_r[9:7];
    assign stack_bytes_out    = stk_r;
    assign code_32k_out       = set_r[11];
    assign code_mirror_en_out = set_r[12];
    assign prefetch_en_out    = set_r[13];
    assign wide_fetch_out     = set_r[14];

    // ****************************************************
    // State tick and throughput estimate
    // ****************************************************
    logic        tick_r, tick_nxt;
    logic [16:0] calc_r, calc_nxt;
    logic [7:0]  res_r, res_nxt;
    logic [7:0]  fetch_st;

    // Fetch-limited states: one per byte paged, else two plus the waits
    always_comb begin
        tick_nxt = ~tick_r;
        fetch_st = 8'(calc_r[2:0]) * (set_r[0] ? 8'd1 : 8'(2 + set_r[6:5]));
        if (calc_r[16])
            fetch_st = 8'd0;
        res_nxt = (calc_r[15:8] > fetch_st) ? calc_r[15:8] : fetch_st;
    end
    assign state_tick_out = tick_r;

    // ****************************************************
    // AHB-Lite slave
    // ****************************************************
    logic        wr_pend_r, wr_pend_nxt;
    logic [7:0]  wr_addr_r, wr_addr_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic        ap;
    assign ap = hsel_in && htrans_in[1] && hready_in;

    // Reads answer with zero wait; unmapped offsets read zero, writes drop
    always_comb begin
        wr_pend_nxt = ap && hwrite_in;
        wr_addr_nxt = haddr_in[7:0];
        calc_nxt    = calc_r;
        rdata_nxt   = rdata_r;
        if (wr_pend_r && wr_addr_r == `ECL_REG_CALC)
            calc_nxt = hwdata_in[16:0];
        if (ap && !hwrite_in) begin
            case (haddr_in[7:0])
                `ECL_REG_CFG0: rdata_nxt = {24'h000000, cfg0_r};
                `ECL_REG_CFG1: rdata_nxt = {24'h000000, cfg1_r};
                `ECL_REG_STAT: rdata_nxt = {15'h0000, done_r, set_r};
                `ECL_REG_CALC: rdata_nxt = {15'h0000, calc_r};
                `ECL_REG_RES:  rdata_nxt = {24'h000000, res_r};
                default:       rdata_nxt = 32'h00000000;
            endcase
        end
    end

    // Bus and estimate registers
    always_ff @(posedge core_clk_in or posedge rst_in) begin
        if (rst_in) begin
            wr_pend_r     <= 1'b0;
            wr_addr_r     <= 8'h00;
            calc_r        <= 17'h00000;
            rdata_r       <= 32'h00000000;
            res_r         <= 8'h00;
            tick_r        <= 1'b0;
            hreadyout_out <= 1'b0;
            hresp_out     <= 1'b0;
        end else if (ce_in) begin
            wr_pend_r     <= wr_pend_nxt;
            wr_addr_r     <= wr_addr_nxt;
            calc_r        <= calc_nxt;
            rdata_r       <= rdata_nxt;
            res_r         <= res_nxt;
            tick_r        <= tick_nxt;
            hreadyout_out <= 1'b1;
            hresp_out     <= 1'b0;
        end
    end
    assign hrdata_out = rdata_r;

    // ****************************************************
    // Assertions
    // ****************************************************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (rst_in);

    sequence s_f1_end;
        ce_in && st_r == ecl_pkg::ST_F1 && last;
    endsequence
    sequence s_applied;
        ce_in ##1 ce_in && st_r == ecl_pkg::ST_DONE ##1 cfg_done_out;
    endsequence

    property p_addr;
        (st_r == ecl_pkg::ST_F1) |-> ext_addr_out == `ECL_CFG1_ADDR;
    endproperty
    a_addr: assert property (p_addr) else $error("wrong byte one address");

    property p_two_fetch;
        (ce_in && st_r == ecl_pkg::ST_F0A && last) |=> st_r == ecl_pkg::ST_F0B
            && page_r == !$past(p21_s);
    endproperty
    a_two_fetch: assert property (p_two_fetch) else $error("page pick lost");

    property p_load;
        s_f1_end |-> s_applied;
    endproperty
    a_load: assert property (p_load) else $error("settings not applied");

    property p_frozen;
        done_r && $past(done_r) |-> $stable(set_r);
    endproperty
    a_frozen: assert property (p_frozen) else $error("settings changed");

    property p_wait_a;
        $rose(done_r) |-> general_wait_out == ~cfg0_r[6:5];
    endproperty
    a_wait_a: assert property (p_wait_a) else $error("general waits wrong");

    property p_wait_b;
        $rose(done_r) |-> region1_wait_out == {1'b0, ~cfg1_r[2:1]} + {2'b00, ~cfg1_r[3]};
    endproperty
    a_wait_b: assert property (p_wait_b) else $error("region one waits wrong");

    property p_frame;
        $rose(done_r) |-> stack_bytes_out == (cfg1_r[4] ? 3'd4 : 3'd2);
    endproperty
    a_frame: assert property (p_frame) else $error("frame size wrong");

    property p_mirror;
        $rose(done_r) |-> code_mirror_en_out == !cfg1_r[0];
    endproperty
    a_mirror: assert property (p_mirror) else $error("mirror wrong");

    property p_tick;
        ce_in ##1 ce_in |-> state_tick_out != $past(state_tick_out);
    endproperty
    a_tick: assert property (p_tick) else $error("state tick stuck");

    property p_max;
        ce_in |=> res_r >= $past(calc_r[15:8]);
    endproperty
    a_max: assert property (p_max) else $error("estimate below exec");

endmodule // ecl_config_loader

/* File: tb/ecl_ext_mem_model.sv */
// Purpose: External code memory holding the two configuration bytes
// Assumes: It answers only while the program store strobe is low
// Notes:   Data turns valid lat_in plus one clocks into each fetch
`timescale 1ns/1ps
module ecl_ext_mem_model (
    // Clock and fetch side
    input  wire logic        clk_in,
    input  wire logic [23:0] addr_in,
    input  wire logic        strobe_n_in,
    // Contents and answer delay
    input  wire logic [7:0]  byte0_in,
    input  wire logic [7:0]  byte1_in,
    input  wire logic [3:0]  lat_in,
    input  wire logic        page_pin_in,
    // Pins
    output logic      [7:0]  data_out,
    output logic             port2_bit1_out
);
    logic [3:0] cnt_r;

    // Released bus shows the inverse of its last value, so stale data never looks valid
    always @(posedge clk_in) begin
        if (strobe_n_in) begin
            cnt_r <= 4'h0;
            data_out <= ~data_out;
        end else begin
            cnt_r <= cnt_r + 4'h1;
            if (cnt_r >= lat_in && addr_in == 24'hfffff8) begin
                data_out <= byte0_in;
            end else if (cnt_r >= lat_in && addr_in == 24'hfffff9) begin
                data_out <= byte1_in;
            end else begin
                data_out <= ~data_out;
            end
        end
    end

    // Port bit idles high on its pull-up outside fetches
    assign port2_bit1_out = strobe_n_in ? 1'b1 : page_pin_in;

    initial data_out = 8'h5a;
endmodule // ecl_ext_mem_model

/* File: tb/ecl_config_loader_tb.sv */
// Purpose: Self-checking bench of the configuration loader
// Assumes: Single-cycle AHB-Lite answers, 40 MHz clock
// Notes:   Four load cases cover every select and wait code
`timescale 1ns/1ps
module ecl_config_loader_tb;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        ce = 1'b1;
    logic        hsel = 1'b1;
    logic        hwrite = 1'b0;
    logic        ext_n = 1'b0;
    logic        pin = 1'b0;
    logic        p2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [1:0]  htrans = 2'b00;
    logic [2:0]  hsize = 3'b010;
    logic [7:0]  ext_data;
    logic [7:0]  oc0 = 8'hff;
    logic [7:0]  oc1 = 8'hff;
    logic [7:0]  b0 = 8'hff;
    logic [7:0]  b1 = 8'hff;
    logic [3:0]  lat = 4'h0;
    logic [31:0] hrdata;
    logic        hready, hresp, strobe_n, done, page, a17, a16, rdsel, rd_all;
    logic        c32, mirror, pref, wide, tick;
    logic [23:0] ext_addr;
    logic [1:0]  gw;
    logic [2:0]  r1w, stk;
    logic [15:0] pv;
    logic        strobe_q = 1'b1;
    logic [23:0] fetches[$];
    int          bad_count = 0;
    int          checked = 0;

    // ************************************************************
    // Clock, design and far side
    // ************************************************************
    always #12.5 clk = ~clk;

    assign pv = {1'b0, wide, pref, mirror, c32, stk == 3'd4, r1w, gw, rd_all, rdsel, a16,
                 a17, page};

    ecl_config_loader ecl_config_loader_i (
        .core_clk_in(clk), .rst_in(rst), .ce_in(ce), .hsel_in(hsel), .haddr_in(haddr),
        .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
        .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(hresp),
        .external_access_n_in(ext_n), .port2_bit1_in(p2), .ext_data_in(ext_data),
        .onchip_cfg0_in(oc0), .onchip_cfg1_in(oc1), .ext_addr_out(ext_addr),
        .program_store_strobe_n_out(strobe_n), .cfg_done_out(done), .page_mode_out(page),
        .port1_bit7_a17_out(a17), .port3_bit7_a16_out(a16), .port3_bit7_rd_out(rdsel),
        .prog_strobe_reads_all_out(rd_all), .general_wait_out(gw), .region1_wait_out(r1w),
        .stack_bytes_out(stk), .code_32k_out(c32), .code_mirror_en_out(mirror),
        .prefetch_en_out(pref), .wide_fetch_out(wide), .state_tick_out(tick));

    ecl_ext_mem_model ecl_ext_mem_model_i (
        .clk_in(clk), .addr_in(ext_addr), .strobe_n_in(strobe_n), .byte0_in(b0),
        .byte1_in(b1), .lat_in(lat), .page_pin_in(pin), .data_out(ext_data),
        .port2_bit1_out(p2));

    // Log the address of every fetch at its strobe fall
    always @(posedge clk) begin
        strobe_q <= strobe_n;
        if (strobe_q === 1'b1 && strobe_n === 1'b0) fetches.push_back(ext_addr);
    end

    // ************************************************************
    // Tasks
    // ************************************************************
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // One single word transfer; data phase held until hready is seen high
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        @(posedge clk);
        haddr <= {24'h0, a};
        htrans <= 2'b10;
        hwrite <= wr;
        do @(posedge clk); while (hready !== 1'b1);
        htrans <= 2'b00;
        hwdata <= wd;
        do @(posedge clk); while (hready !== 1'b1);
        rd = hrdata;
        check("response", {31'h0, hresp}, 32'h0);
    endtask

    task automatic conclude();
        $display("Comparisons %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask

    // Settings vector worked out from the two bytes and the source
    function automatic logic [15:0] exp_vec(logic [7:0] c0, logic [7:0] c1, logic ext,
                                            logic pg);
        logic [1:0] s;
        logic [2:0] w;
        s = c0[3:2];
        w = {1'b0, ~c1[2:1]} + {2'b00, ~c1[3]};
        return {1'b0, ~ext, ext, ~c1[0], c1[7], c1[4], w, ~c0[6:5], s != 2'b11, s == 2'b11,
                s[1] == 1'b0, s == 2'b00, ext ? ~pg : ~c0[1]};
    endfunction

    // One reset-time load, then pins, registers and throughput
    task automatic run_case(input int i);
        logic [7:0]  c0, c1;
        logic [15:0] v;
        logic [31:0] rd;
        logic        ext, t;
        int          n, f;
        ext = ~i[0];
        c0 = {1'b1, 2'(i), 1'b1, 2'(i), i[1], 1'b1};
        c1 = {i[0], 2'b11, i[1], i != 3, 2'(i), i[0]};
        @(posedge clk);
        rst <= 1'b1;
        ext_n <= ~ext;
        {oc0, oc1, b0, b1} <= {c0, c1, c0, c1};
        pin <= i[1];
        lat <= i[1] ? 4'h6 : 4'h0;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        fetches.delete();
        n = 0;
        while (done !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
        end
        #1;
        v = exp_vec(c0, c1, ext, i[1]);
        check("settings pins", {16'h0, pv}, {16'h0, v});
        check("frame bytes", {29'h0, stk}, c1[4] ? 4 : 2);
        check("fetch count", fetches.size(), ext ? 3 : 0);
        foreach (fetches[k]) check("fetch addr", {8'h0, fetches[k]}, k < 2 ? 32'hfffff8 :
                                   32'hfffff9);
        t = tick;
        @(posedge clk);
        #1;
        check("state tick", {31'h0, tick}, {31'h0, ~t});
        // Enable low must hold every state, the tick included
        @(posedge clk);
        ce <= 1'b0;
        repeat (2) @(posedge clk);
        #1;
        t = tick;
        repeat (3) @(posedge clk);
        #1;
        check("held tick", {31'h0, tick}, {31'h0, t});
        @(posedge clk);
        ce <= 1'b1;
        bus(1'b0, 8'h08, 32'h0, rd);
        check("status", rd, {15'h0, 1'b1, v});
        bus(1'b1, 8'h00, 32'hffffffff, rd);
        bus(1'b0, 8'h00, 32'h0, rd);
        check("byte zero", rd, {24'h0, c0});
        bus(1'b0, 8'h04, 32'h0, rd);
        check("byte one", rd, {24'h0, c1});
        bus(1'b0, 8'h14, 32'h0, rd);
        check("unmapped", rd, 32'h0);
        bus(1'b1, 8'h0c, {15'h0, ~ext, 8'h07, 5'h0, 3'h3}, rd);
        repeat (2) @(posedge clk);
        bus(1'b0, 8'h10, 32'h0, rd);
        f = ext ? 3 * (v[0] ? 1 : 2 + int'(v[6:5])) : 0;
        check("throughput", rd, f > 7 ? f : 7);
        bus(1'b0, 8'h0c, 32'h0, rd);
        check("calc", rd, {15'h0, ~ext, 8'h07, 5'h0, 3'h3});
        // Sources change after the load; nothing may follow them
        @(posedge clk);
        {oc0, oc1, b0, b1} <= ~{c0, c1, c0, c1};
        ext_n <= ext;
        repeat (20) @(posedge clk);
        #1;
        check("frozen settings", {16'h0, pv}, {16'h0, v});
    endtask

    // ************************************************************
    // Main sequence and watchdog
    // ************************************************************
    initial begin
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 4; i++) run_case(i);
        conclude();
    end

    // Four cases take well under 2000 clocks
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        conclude();
    end
endmodule // ecl_config_loader_tb
